/* File: logic/irq_ctrl_pkg.sv */
/*
 * Shared constants and carriers of the prioritised interrupt controller.
 * Assumes a 16-bit register port with word indices on an 8-bit address.
 */
package irq_ctrl_pkg;

	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h01;
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h02;
	localparam logic [7:0] ADDR_CONTROL_FOUR = 8'h03;
	localparam logic [7:0] ADDR_PENDING_VECTOR = 8'h04;
	localparam logic [7:0] ADDR_STATUS_WORD = 8'h05;
	localparam logic [7:0] ADDR_CORE_CONTROL = 8'h06;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_ENABLES = 8'h09;
	localparam logic [7:0] ADDR_PRIORITY_BASE = 8'h0a;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int NEST_DIS_BIT = 15;
	localparam int OSC_FAIL_BIT = 1;
	localparam int STACK_ERR_BIT = 2;
	localparam int ADDR_ERR_BIT = 3;
	localparam int MATH_ERR_BIT = 4;
	localparam int GLOBAL_EN_BIT = 15;
	localparam int DMA_ERR_BIT = 5;
	localparam int LOOP_OVF_BIT = 4;
	localparam int SOFT_TRAP_BIT = 0;
	localparam int STATUS_LEVEL_LSB = 5;
	localparam int CORE_TOP_BIT = 3;
	localparam int LEVEL_FIELD_LSB = 8;
	localparam int PRIO_FIELD_WIDTH = 4;
	localparam int PRIO_PER_REG = 4;

	// ----------------------------------------
	// reset values and fixed numbers
	// ----------------------------------------
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [2:0] RESET_PRIORITY = 3'h4;
	localparam logic [2:0] MAX_USER_LEVEL = 3'h7;
	localparam logic [7:0] FIRST_VECTOR = 8'h08;

	typedef struct packed {
		logic [7:0] vector;
		logic [3:0] level;
	} vector_info_type;

	typedef struct packed {
		logic osc_fail;
		logic stack_err;
		logic addr_err;
		logic math_err;
		logic dma_err;
		logic loop_ovf;
		logic soft_trap;
	} trap_event_type;

endpackage : irq_ctrl_pkg

/* File: logic/level_sync.sv */
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes the reset given is already synchronous to clk release.
 */
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : level_sync

/* File: logic/source_arbiter.sv */
/*
 * Combinational selection of the highest priority admitted request.
 * Assumes requests are already gated by flag, enable and global enable.
 */
`timescale 1ns/1ps
module source_arbiter #(
	parameter int SOURCES = 16
) (
	input wire logic [SOURCES-1:0] request,
	input wire logic [SOURCES*3-1:0] priority_flat,
	input wire logic [3:0] current_level,
	output logic winner_valid,
	output logic [7:0] winner_index,
	output logic [2:0] winner_priority
);

	always_comb begin
		logic found;
		found = 1'b0;
		winner_index = 8'h00;
		winner_priority = 3'h0;
		// strict compare keeps the lower index on a tie
		for (int i = 0; i < SOURCES; i++) begin
			if (request[i] && (!found || priority_flat[i*3 +: 3] > winner_priority)) begin
				found = 1'b1;
				winner_index = 8'(i);
				winner_priority = priority_flat[i*3 +: 3];
			end
		end
		winner_valid = found && ({1'b0, winner_priority} > current_level);
	end

endmodule : source_arbiter

/* File: logic/priority_irq_controller.sv */
/*
 * Vectored prioritised interrupt controller with trap status, nesting
 * control and current-priority tracking.
 * Assumes a single-cycle register port master, asynchronous external
 * request pins, and a core that acks a taken vector or trap with one pulse
 * and returns with its stacked level.
 */
`timescale 1ns/1ps

// Summary of operation
// - each source has a request flag set by hardware and cleared only by a software write.
// - each source has its own enable bit that admits or blocks it alone.
// - each user source has a programmable priority of one of eight levels.
// - a selected interrupt latches its 8-bit vector and 4-bit new level into a readable register.
// - the latched new level equals the programmed priority of the selected source.
// - sources sit in vector order, external request zero at bit 0, vector 8, priority bits 2:0.
// - the status word holds the low three current level bits at 7:5, rewritable by software except while nesting is disabled during a handler.
// - a read-only top level bit in the core control register completes the current level.
// - control register two holds the global enable and external request line settings.
// - control register one holds nesting disable and the processor trap flags.
// - control register three holds the DMA trap and loop-stack overflow flags.
// - control register four holds the software hard trap flag.
module priority_irq_controller #(
	parameter int SOURCES = 16,
	parameter int EXT_LINES = 3
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic [SOURCES-1:0] periph_req,
	input wire logic [EXT_LINES-1:0] ext_irq_pin,
	input wire irq_ctrl_pkg::trap_event_type trap_event,
	input wire logic core_ack,
	input wire logic trap_ack,
	input wire logic core_return,
	input wire logic [3:0] restore_level,
	output logic irq_request,
	output irq_ctrl_pkg::vector_info_type pending_vector,
	output logic trap_pending,
	output logic [3:0] cpu_level,
	output logic irq_out
);

	localparam int PRIO_REGS = (SOURCES + irq_ctrl_pkg::PRIO_PER_REG - 1) / 4;

	if (SOURCES < 1 || SOURCES > 16 || EXT_LINES < 1 || EXT_LINES > SOURCES) begin : bad_params
		$error("priority_irq_controller: unsupported SOURCES or EXT_LINES");
	end

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_reg;
	logic rst_sync_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n <= rst_meta_reg;
		end
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [SOURCES-1:0] flag_reg;
	logic [SOURCES-1:0] enable_reg;
	logic [SOURCES*3-1:0] prio_reg;
	logic nest_dis_reg;
	logic global_irq_enable_reg;
	logic [EXT_LINES-1:0] ext_fall_reg;
	irq_ctrl_pkg::trap_event_type trap_flag_reg;
	logic [2:0] cpu_low_reg;
	logic cpu_top_reg;
	logic servicing_reg;
	logic [EXT_LINES-1:0] ext_sync;
	logic [EXT_LINES-1:0] ext_prev_reg;
	logic [EXT_LINES-1:0] ext_edge;
	logic [SOURCES-1:0] set_req;
	logic wr_hit_flags;
	logic winner_valid;
	logic [7:0] winner_index;
	logic [2:0] winner_priority;
	logic [15:0] read_value;

	assign wr_hit_flags = reg_write && reg_addr == irq_ctrl_pkg::ADDR_FLAGS;

	// ----------------------------------------
	// external request lines
	// ----------------------------------------
	level_sync #(
		.WIDTH(EXT_LINES)
	) ext_sync_inst (
		.mclk(mclk),
		.rst_n(rst_sync_n),
		.async_in(ext_irq_pin),
		.sync_out(ext_sync)
	);

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ext_prev_reg <= '0;
		end else begin
			ext_prev_reg <= ext_sync;
		end
	end

	// edge polarity per line from control register two
	assign ext_edge = ext_fall_reg & ext_prev_reg & ~ext_sync
		| ~ext_fall_reg & ~ext_prev_reg & ext_sync;

	// external line n drives source n, so line zero is bit 0 / vector 8
	assign set_req = periph_req | SOURCES'(ext_edge);

	// ----------------------------------------
	// request flags and enables
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flag_reg <= '0;
		end else begin
			// a new request in the clearing cycle survives the clear
			flag_reg <= (flag_reg & ~(wr_hit_flags ? reg_wdata[SOURCES-1:0] : '0))
				| set_req;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			enable_reg <= '0;
		end else if (reg_write && reg_addr == irq_ctrl_pkg::ADDR_ENABLES) begin
			enable_reg <= reg_wdata[SOURCES-1:0];
		end
	end

	// ----------------------------------------
	// priority fields, four per register
	// ----------------------------------------
	generate
		for (genvar i = 0; i < SOURCES; i++) begin : prio_field
			localparam logic [7:0] ADDR_OWN = irq_ctrl_pkg::ADDR_PRIORITY_BASE + 8'(i / 4);
			localparam int LSB = (i % irq_ctrl_pkg::PRIO_PER_REG) * irq_ctrl_pkg::PRIO_FIELD_WIDTH;
			always_ff @(posedge mclk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					prio_reg[i*3 +: 3] <= irq_ctrl_pkg::RESET_PRIORITY;
				end else if (reg_write && reg_addr == ADDR_OWN) begin
					prio_reg[i*3 +: 3] <= reg_wdata[LSB +: 3];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			nest_dis_reg <= 1'b0;
		end else if (reg_write && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_ONE) begin
			nest_dis_reg <= reg_wdata[irq_ctrl_pkg::NEST_DIS_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			global_irq_enable_reg <= 1'b0;
			ext_fall_reg <= '0;
		end else if (reg_write && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_TWO) begin
			global_irq_enable_reg <= reg_wdata[irq_ctrl_pkg::GLOBAL_EN_BIT];
			ext_fall_reg <= reg_wdata[EXT_LINES-1:0];
		end
	end

	// ----------------------------------------
	// trap flags, write one to clear
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			trap_flag_reg <= '0;
		end else begin
			if (reg_write && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_ONE) begin
				trap_flag_reg.osc_fail <= trap_flag_reg.osc_fail
					& ~reg_wdata[irq_ctrl_pkg::OSC_FAIL_BIT] | trap_event.osc_fail;
				trap_flag_reg.stack_err <= trap_flag_reg.stack_err
					& ~reg_wdata[irq_ctrl_pkg::STACK_ERR_BIT] | trap_event.stack_err;
				trap_flag_reg.addr_err <= trap_flag_reg.addr_err
					& ~reg_wdata[irq_ctrl_pkg::ADDR_ERR_BIT] | trap_event.addr_err;
				trap_flag_reg.math_err <= trap_flag_reg.math_err
					& ~reg_wdata[irq_ctrl_pkg::MATH_ERR_BIT] | trap_event.math_err;
			end else begin
				trap_flag_reg.osc_fail <= trap_flag_reg.osc_fail | trap_event.osc_fail;
				trap_flag_reg.stack_err <= trap_flag_reg.stack_err | trap_event.stack_err;
				trap_flag_reg.addr_err <= trap_flag_reg.addr_err | trap_event.addr_err;
				trap_flag_reg.math_err <= trap_flag_reg.math_err | trap_event.math_err;
			end
			if (reg_write && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_THREE) begin
				trap_flag_reg.dma_err <= trap_flag_reg.dma_err
					& ~reg_wdata[irq_ctrl_pkg::DMA_ERR_BIT] | trap_event.dma_err;
				trap_flag_reg.loop_ovf <= trap_flag_reg.loop_ovf
					& ~reg_wdata[irq_ctrl_pkg::LOOP_OVF_BIT] | trap_event.loop_ovf;
			end else begin
				trap_flag_reg.dma_err <= trap_flag_reg.dma_err | trap_event.dma_err;
				trap_flag_reg.loop_ovf <= trap_flag_reg.loop_ovf | trap_event.loop_ovf;
			end
			if (reg_write && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_FOUR) begin
				trap_flag_reg.soft_trap <= trap_flag_reg.soft_trap
					& ~reg_wdata[irq_ctrl_pkg::SOFT_TRAP_BIT] | trap_event.soft_trap;
			end else begin
				trap_flag_reg.soft_trap <= trap_flag_reg.soft_trap | trap_event.soft_trap;
			end
		end
	end

	assign trap_pending = |trap_flag_reg;

	// ----------------------------------------
	// selection
	// ----------------------------------------
	source_arbiter #(
		.SOURCES(SOURCES)
	) arbiter_inst (
		.request(flag_reg & enable_reg & {SOURCES{global_irq_enable_reg}}),
		.priority_flat(prio_reg),
		.current_level(cpu_level),
		.winner_valid(winner_valid),
		.winner_index(winner_index),
		.winner_priority(winner_priority)
	);

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= winner_valid && !core_ack;
		end
	end

	// holds the last selection once the request falls away
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pending_vector <= '0;
		end else if (winner_valid) begin
			pending_vector.vector <= irq_ctrl_pkg::FIRST_VECTOR + winner_index;
			pending_vector.level <= {1'b0, winner_priority};
		end
	end

	// ----------------------------------------
	// current processor level
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cpu_low_reg <= 3'h0;
			cpu_top_reg <= 1'b0;
			servicing_reg <= 1'b0;
		end else if (trap_ack) begin
			cpu_top_reg <= 1'b1;
			servicing_reg <= 1'b1;
		end else if (core_ack && irq_request) begin
			cpu_low_reg <= nest_dis_reg ? irq_ctrl_pkg::MAX_USER_LEVEL
				: pending_vector.level[2:0];
			servicing_reg <= 1'b1;
		end else if (core_return) begin
			cpu_low_reg <= restore_level[2:0];
			cpu_top_reg <= restore_level[3];
			servicing_reg <= 1'b0;
		end else if (reg_write && reg_addr == irq_ctrl_pkg::ADDR_STATUS_WORD
				&& !(nest_dis_reg && servicing_reg)) begin
			// top bit has no register write path, only trap_ack and core_return load it, traps stay unmaskable
			cpu_low_reg <= reg_wdata[irq_ctrl_pkg::STATUS_LEVEL_LSB +: 3];
		end
	end

	assign cpu_level = {cpu_top_reg, cpu_low_reg};

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(flag_reg & enable_reg);
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always_comb begin
		read_value = irq_ctrl_pkg::RESET_WORD;
		unique case (reg_addr)
			irq_ctrl_pkg::ADDR_CONTROL_ONE: begin
				read_value[irq_ctrl_pkg::NEST_DIS_BIT] = nest_dis_reg;
				read_value[irq_ctrl_pkg::OSC_FAIL_BIT] = trap_flag_reg.osc_fail;
				read_value[irq_ctrl_pkg::STACK_ERR_BIT] = trap_flag_reg.stack_err;
				read_value[irq_ctrl_pkg::ADDR_ERR_BIT] = trap_flag_reg.addr_err;
				read_value[irq_ctrl_pkg::MATH_ERR_BIT] = trap_flag_reg.math_err;
			end
			irq_ctrl_pkg::ADDR_CONTROL_TWO: begin
				read_value[irq_ctrl_pkg::GLOBAL_EN_BIT] = global_irq_enable_reg;
				read_value[EXT_LINES-1:0] = ext_fall_reg;
			end
			irq_ctrl_pkg::ADDR_CONTROL_THREE: begin
				read_value[irq_ctrl_pkg::DMA_ERR_BIT] = trap_flag_reg.dma_err;
				read_value[irq_ctrl_pkg::LOOP_OVF_BIT] = trap_flag_reg.loop_ovf;
			end
			irq_ctrl_pkg::ADDR_CONTROL_FOUR: begin
				read_value[irq_ctrl_pkg::SOFT_TRAP_BIT] = trap_flag_reg.soft_trap;
			end
			irq_ctrl_pkg::ADDR_PENDING_VECTOR: begin
				read_value[7:0] = pending_vector.vector;
				read_value[irq_ctrl_pkg::LEVEL_FIELD_LSB +: 4] = pending_vector.level;
			end
			irq_ctrl_pkg::ADDR_STATUS_WORD: begin
				read_value[irq_ctrl_pkg::STATUS_LEVEL_LSB +: 3] = cpu_low_reg;
			end
			irq_ctrl_pkg::ADDR_CORE_CONTROL: begin
				read_value[irq_ctrl_pkg::CORE_TOP_BIT] = cpu_top_reg;
			end
			irq_ctrl_pkg::ADDR_FLAGS: begin
				read_value[SOURCES-1:0] = flag_reg;
			end
			irq_ctrl_pkg::ADDR_ENABLES: begin
				read_value[SOURCES-1:0] = enable_reg;
			end
			default: begin
				for (int r = 0; r < PRIO_REGS; r++) begin
					if (reg_addr == irq_ctrl_pkg::ADDR_PRIORITY_BASE + 8'(r)) begin
						for (int k = 0; k < 4; k++) begin
							if (r * 4 + k < SOURCES) begin
								read_value[k*4 +: 3] = prio_reg[(r*4+k)*3 +: 3];
							end
						end
					end
				end
			end
		endcase
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= irq_ctrl_pkg::RESET_WORD;
		end else begin
			reg_rdata <= reg_read ? read_value : irq_ctrl_pkg::RESET_WORD;
		end
	end

endmodule : priority_irq_controller

/* File: testbench/priority_irq_controller_sva.sv */
/*
 * Port-level checks of the interrupt controller, bound into it.
 * Assumes the core never acks and returns in one cycle.
 */
`timescale 1ns/1ps
module priority_irq_controller_sva #(
	parameter int SOURCES = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire irq_ctrl_pkg::trap_event_type trap_event,
	input wire logic core_ack,
	input wire logic trap_ack,
	input wire logic core_return,
	input wire logic [3:0] restore_level,
	input wire logic irq_request,
	input wire irq_ctrl_pkg::vector_info_type pending_vector,
	input wire logic trap_pending,
	input wire logic [3:0] cpu_level
);
	logic [3:0] pend_level;
	logic top_bit;
	assign pend_level = pending_vector.level;
	assign top_bit = cpu_level[3];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_read_data_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_ack_drops_request: assert property (core_ack && irq_request && !trap_ack |=> !irq_request)
		else $error("request stayed after ack");
	a_ack_raises_level: assert property (core_ack && irq_request && !trap_ack && !core_return
		|=> {1'b0, cpu_level[2:0]} >= $past(pend_level))
		else $error("level below taken priority");
	a_req_above_level: assert property (irq_request |-> pend_level > $past(cpu_level))
		else $error("request not above level");
	a_vector_in_range: assert property (irq_request |-> pending_vector.vector >= 8'h08
		&& pending_vector.vector < 8'h08 + 8'(SOURCES))
		else $error("vector out of range");
	a_trap_sets_top: assert property (trap_ack && !core_return |=> top_bit)
		else $error("trap left top bit clear");
	a_top_bit_held: assert property (!trap_ack && !core_return |=> $stable(top_bit))
		else $error("top bit moved");
	a_return_restores: assert property (core_return && !trap_ack |=> cpu_level == $past(restore_level))
		else $error("level not restored");
	a_trap_pending_set: assert property (trap_event != 7'h00 |=> trap_pending)
		else $error("trap not pending");

	c_vector_taken: cover property (core_ack && irq_request);
	c_trap_taken: cover property (trap_ack);
	c_top_priority: cover property (irq_request && pend_level == 4'h7);
endmodule : priority_irq_controller_sva

bind priority_irq_controller priority_irq_controller_sva #(.SOURCES(SOURCES)) sva_inst (
	.mclk(mclk), .rst_n(rst_n), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.trap_event(trap_event), .core_ack(core_ack), .trap_ack(trap_ack),
	.core_return(core_return), .restore_level(restore_level), .irq_request(irq_request),
	.pending_vector(pending_vector), .trap_pending(trap_pending), .cpu_level(cpu_level)
);

/* File: testbench/core_model.sv */
/*
 * Processor core model: takes vectors and traps, returns after a fixed handler.
 * Assumes the controller's pulse handshake; ack_delay sets how slowly it acks a vector, traps are acked at once.
 */
`timescale 1ns/1ps
module core_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] ack_delay,
	input wire logic irq_request,
	input wire logic trap_pending,
	input wire logic [3:0] cpu_level,
	output logic core_ack,
	output logic trap_ack,
	output logic core_return,
	output logic [3:0] restore_level
);
	logic busy_reg;
	logic seen_reg;
	logic [3:0] wait_reg;
	logic [3:0] hold_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{core_ack, trap_ack, core_return, busy_reg, seen_reg} <= 5'h00;
			{wait_reg, hold_reg, restore_level} <= 12'h000;
		end else begin
			core_ack <= 1'b0;
			trap_ack <= 1'b0;
			core_return <= 1'b0;
			if (busy_reg) begin
				hold_reg <= hold_reg + 4'h1;
				// handler length fixed at sixteen cycles
				if (hold_reg == 4'hf) begin
					core_return <= 1'b1;
					busy_reg <= 1'b0;
				end
			end else begin
				seen_reg <= trap_pending;
				hold_reg <= 4'h0;
				wait_reg <= irq_request ? wait_reg + 4'h1 : 4'h0;
				if (trap_pending && !seen_reg) begin
					trap_ack <= 1'b1;
					restore_level <= cpu_level;
					busy_reg <= 1'b1;
				end else if (irq_request && wait_reg >= ack_delay) begin
					core_ack <= 1'b1;
					restore_level <= cpu_level;
					busy_reg <= 1'b1;
					wait_reg <= 4'h0;
				end
			end
		end
	end
endmodule : core_model

/* File: testbench/priority_irq_controller_tb_top.sv */
/*
 * Self-checking bench of the interrupt controller with the core model.
 * Assumes the default of sixteen sources and three external lines.
 */
`timescale 1ns/1ps
module priority_irq_controller_tb_top;
	logic mclk, rst_n, reg_write, reg_read, core_ack, trap_ack, core_return;
	logic irq_request, trap_pending, irq_out;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, periph_req, en, word;
	logic [2:0] ext_irq_pin;
	logic [3:0] restore_level, cpu_level, ack_delay;
	irq_ctrl_pkg::trap_event_type trap_event;
	irq_ctrl_pkg::vector_info_type pending_vector;
	logic [31:0] seed;
	logic [47:0] prio;
	logic [12:0] win;
	logic [7:0] tr_addr [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h03};
	int tr_bit [7] = '{1, 2, 3, 4, 5, 4, 0};
	int n_mismatch;
	int n_checks;

	priority_irq_controller priority_irq_controller_inst (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .periph_req(periph_req), .ext_irq_pin(ext_irq_pin),
		.trap_event(trap_event), .core_ack(core_ack), .trap_ack(trap_ack),
		.core_return(core_return), .restore_level(restore_level), .irq_request(irq_request),
		.pending_vector(pending_vector), .trap_pending(trap_pending), .cpu_level(cpu_level),
		.irq_out(irq_out));
	core_model core_model_inst (.mclk(mclk), .rst_n(rst_n), .ack_delay(ack_delay),
		.irq_request(irq_request), .trap_pending(trap_pending), .cpu_level(cpu_level),
		.core_ack(core_ack), .trap_ack(trap_ack), .core_return(core_return),
		.restore_level(restore_level));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// descending scan with >= lets the lower index win a tie
	function automatic logic [12:0] pick(input logic [15:0] fl, input logic [47:0] pr);
		logic [12:0] best;
		best = 13'h0000;
		for (int i = 15; i >= 0; i--) begin
			if (fl[i] && pr[i*3 +: 3] != 3'h0 && {1'b0, pr[i*3 +: 3]} >= best[3:0]) begin
				best = {1'b1, 8'h08 + 8'(i), 1'b0, pr[i*3 +: 3]};
			end
		end
		return best;
	endfunction : pick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rc
	task automatic pulse(input logic [15:0] r);
		@(posedge mclk);
		periph_req <= r;
		@(posedge mclk);
		periph_req <= 16'h0000;
		cyc(1);
	endtask : pulse
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(3);
	endtask : do_reset
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#(100 * 5000);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{reg_write, reg_read, reg_addr, reg_wdata} = 26'h000_0000;
		{periph_req, ext_irq_pin, ack_delay} = 23'h00_0000;
		trap_event = 7'h00;
		seed = 32'h2ec0_0a74;
		do_reset();
		// ----
		// reset values, unmapped and read-only places
		// ----
		wr(8'h07, 16'hffff);
		for (int a = 0; a < 16; a++) begin
			rc(8'(a), (a >= 10 && a <= 13) ? 16'h4444 : 16'h0000);
		end
		wr(8'h0d, 16'hffff);
		rc(8'h0d, 16'h7777);
		wr(irq_ctrl_pkg::ADDR_CORE_CONTROL, 16'h0008);
		rc(irq_ctrl_pkg::ADDR_CORE_CONTROL, 16'h0000);
		wr(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h00a0);
		rc(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h00a0);
		chk({12'h000, cpu_level}, 16'h0005);
		// ----
		// global enable and level gating
		// ----
		wr(irq_ctrl_pkg::ADDR_ENABLES, 16'h0008);
		wr(8'h0a, 16'h5444);
		pulse(16'h0008);
		chk({15'h0000, irq_request}, 16'h0000);
		chk({15'h0000, irq_out}, 16'h0001);
		wr(irq_ctrl_pkg::ADDR_CONTROL_TWO, 16'h8000);
		cyc(1);
		chk({15'h0000, irq_request}, 16'h0000);
		wr(8'h0a, 16'h6444);
		cyc(1);
		chk({15'h0000, irq_request}, 16'h0001);
		chk({4'h0, pending_vector}, 16'h00b6);
		cyc(4);
		chk({12'h000, cpu_level}, 16'h0006);
		wr(irq_ctrl_pkg::ADDR_FLAGS, 16'hffff);
		cyc(20);
		chk({12'h000, cpu_level}, 16'h0005);
		wr(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h0000);
		// ----
		// random priorities, enables and requests
		// ----
		for (int it = 0; it < 16; it++) begin
			for (int r = 0; r < 4; r++) begin
				seed = lfsr(seed);
				word = seed[15:0] & 16'h7777;
				wr(irq_ctrl_pkg::ADDR_PRIORITY_BASE + 8'(r), word);
				for (int k = 0; k < 4; k++) prio[(r*4+k)*3 +: 3] = word[k*4 +: 3];
			end
			seed = lfsr(seed);
			en = seed[31:16];
			ack_delay <= seed[3:0];
			wr(irq_ctrl_pkg::ADDR_ENABLES, en);
			seed = lfsr(seed);
			pulse(seed[15:0]);
			win = pick(seed[15:0] & en, prio);
			chk({15'h0000, irq_request}, {15'h0000, win[12]});
			chk({15'h0000, irq_out}, {15'h0000, |(seed[15:0] & en)});
			if (win[12]) chk({4'h0, pending_vector}, {4'h0, win[11:0]});
			if (win[12]) rc(irq_ctrl_pkg::ADDR_PENDING_VECTOR, {4'h0, win[3:0], win[11:4]});
			rc(irq_ctrl_pkg::ADDR_FLAGS, seed[15:0]);
			wr(irq_ctrl_pkg::ADDR_FLAGS, 16'hffff);
			rc(irq_ctrl_pkg::ADDR_FLAGS, 16'h0000);
			cyc(40);
		end
		// ----
		// nesting disabled holds the top user level
		// ----
		ack_delay <= 4'h0;
		wr(irq_ctrl_pkg::ADDR_ENABLES, 16'hffff);
		wr(8'h0b, 16'h0002);
		wr(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h8000);
		rc(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h8000);
		pulse(16'h0010);
		cyc(4);
		chk({12'h000, cpu_level}, 16'h0007);
		wr(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h0000);
		#1;
		chk({12'h000, cpu_level}, 16'h0007);
		wr(irq_ctrl_pkg::ADDR_FLAGS, 16'hffff);
		cyc(30);
		wr(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h0000);
		// ----
		// every trap source
		// ----
		for (int i = 0; i < 7; i++) begin
			@(posedge mclk);
			trap_event <= irq_ctrl_pkg::trap_event_type'(7'h40 >> i);
			@(posedge mclk);
			trap_event <= 7'h00;
			cyc(2);
			chk({15'h0000, cpu_level[3]}, 16'h0001);
			rc(tr_addr[i], 16'h0001 << tr_bit[i]);
			wr(tr_addr[i], 16'h0001 << tr_bit[i]);
			rc(tr_addr[i], 16'h0000);
			cyc(20);
		end
		// ----
		// external line zero, both edges
		// ----
		wr(irq_ctrl_pkg::ADDR_PRIORITY_BASE, 16'h0007);
		ext_irq_pin <= 3'b001;
		cyc(6);
		rc(irq_ctrl_pkg::ADDR_FLAGS, 16'h0001);
		rc(irq_ctrl_pkg::ADDR_PENDING_VECTOR, 16'h0708);
		wr(irq_ctrl_pkg::ADDR_FLAGS, 16'hffff);
		wr(irq_ctrl_pkg::ADDR_CONTROL_TWO, 16'h8001);
		ext_irq_pin <= 3'b000;
		cyc(6);
		rc(irq_ctrl_pkg::ADDR_FLAGS, 16'h0001);
		cyc(30);
		do_reset();
		chk({12'h000, cpu_level}, 16'h0000);
		rc(irq_ctrl_pkg::ADDR_PRIORITY_BASE, 16'h4444);
		tally_and_finish();
	end
endmodule : priority_irq_controller_tb_top
